// file: hw/legacy_addr_match.v
// Address comparisons for one bus: I/O window, alias holes and VGA ranges.
// Purely combinational; the caller registers the results.
`include "legacy_decode_defs.vh"

module legacy_addr_match (
   input wire [31:0] addr_in,
   input wire [31:0] io_base_in,
   input wire [31:0] io_limit_in,
   output wire in_window_out,
   output wire low64k_alias_out,
   output wire vga_io_out,
   output wire vga_mem_out
);
   wire low64k;
   wire [9:0] lo10;

   assign low64k = (addr_in[31:16] == 16'h0000);
   assign lo10 = addr_in[9:0];
   // Window is 4 KB granular: base low bits are zero, limit low bits ones.
   assign in_window_out = (addr_in[31:12] >= io_base_in[31:12]) &&
                          (addr_in[31:12] <= io_limit_in[31:12]);
   // Upper 768 bytes of every 1 KB block below 64 KB.
   assign low64k_alias_out = low64k && (addr_in[9:8] != 2'b00);
   assign vga_io_out = low64k &&
      (((lo10 >= `VGA_IO_LO1) && (lo10 <= `VGA_IO_HI1)) ||
       ((lo10 >= `VGA_IO_LO2) && (lo10 <= `VGA_IO_HI2)));
   assign vga_mem_out = (addr_in >= `VGA_MEM_LO) && (addr_in <= `VGA_MEM_HI);
endmodule // legacy_addr_match

// file: hw/legacy_decode_ctrl.v
// Error forwarding and legacy address decode control of a bus bridge,
// with its configuration registers behind an AXI4-Lite slave.
// Assumes all inputs are synchronous to CLK_IN and error inputs are
// single-cycle detection strobes from the secondary bus interface.
//
// Local design decision: the AXI4-Lite register port.
`include "legacy_decode_defs.vh"

module legacy_decode_ctrl (
   input wire CLK_IN,
   input wire RESETN_IN,
   // AXI4-Lite slave.
   input wire [11:0] AWADDR_IN,
   input wire AWVALID_IN,
   output wire AWREADY_OUT,
   input wire [31:0] WDATA_IN,
   input wire [3:0] WSTRB_IN,
   input wire WVALID_IN,
   output wire WREADY_OUT,
   output wire [1:0] BRESP_OUT,
   output wire BVALID_OUT,
   input wire BREADY_IN,
   input wire [11:0] ARADDR_IN,
   input wire ARVALID_IN,
   output wire ARREADY_OUT,
   output wire [31:0] RDATA_OUT,
   output wire [1:0] RRESP_OUT,
   output wire RVALID_OUT,
   input wire RREADY_IN,
   // Secondary error detection.
   input wire S_DATA_PERR_DET_IN,
   input wire S_BRIDGE_MASTER_IN,
   input wire S_ADDR_PERR_DET_IN,
   input wire S_SERR_N_IN,
   // Error pins, open drain.
   output wire S_PERR_N_OUT,
   output wire S_PERR_OE_OUT,
   output wire P_SERR_N_OUT,
   output wire P_SERR_OE_OUT,
   // Primary transaction decode.
   input wire P_REQ_VALID_IN,
   input wire P_REQ_IS_IO_IN,
   input wire [31:0] P_REQ_ADDR_IN,
   output wire P_CLAIM_OUT,
   // Secondary transaction decode.
   input wire S_REQ_VALID_IN,
   input wire S_REQ_IS_IO_IN,
   input wire [31:0] S_REQ_ADDR_IN,
   output wire S_CLAIM_OUT,
   output wire IRQ_OUT
);
   reg [31:0] ctrl_q;
   reg [31:0] cmd_q;
   reg [31:0] io_base_q;
   reg [31:0] io_limit_q;
   reg [`STAT_W-1:0] mask_q;
   wire [`STAT_W-1:0] stat_q;
   reg [`STAT_W-1:0] stat_set;

   reg awready_q;
   reg wready_q;
   reg aw_have_q;
   reg w_have_q;
   reg [11:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg arready_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   reg s_perr_q;
   reg s_perr_n_q;
   reg p_serr_q;
   reg p_serr_n_q;
   reg p_claim_q;
   reg s_claim_q;
   reg irq_q;

   wire perr_resp;
   wire serr_fwd;
   wire alias_mode;
   wire vga_mode;
   wire io_en;
   wire mem_en;
   wire serr_en;
   wire vga_ok;
   wire wr_go;
   wire rd_go;
   wire stat_rd;
   wire p_in_win;
   wire p_alias;
   wire p_vga_io;
   wire p_vga_mem;
   wire s_in_win;
   wire s_alias;
   wire s_vga_io;
   wire s_vga_mem;
   wire p_io_hit;
   wire s_io_hit;
   wire addr_perr_report;
   wire sec_serr_report;
   reg [31:0] rd_mux;
   reg rd_hit;
   reg wr_hit;

   assign perr_resp = ctrl_q[`CTRL_PERR_RESP];
   assign serr_fwd = ctrl_q[`CTRL_SERR_FWD];
   assign alias_mode = ctrl_q[`CTRL_ALIAS];
   assign vga_mode = ctrl_q[`CTRL_VGA];
   assign io_en = cmd_q[`CMD_IO_EN];
   assign mem_en = cmd_q[`CMD_MEM_EN];
   assign serr_en = cmd_q[`CMD_SERR_EN];

   // Merges write data into a register under byte strobes and a field mask.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      input [31:0] wmask;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
               merge[i*8 +: 8] = data[i*8 +: 8];
         end
         merge = merge & wmask;
      end
   endfunction

   // Write channel: address and data are taken in either order.
   assign wr_go = aw_have_q && w_have_q && !bvalid_q;

   always @*
   begin
      case (awaddr_q)
         `CTRL_ADDR: wr_hit = 1'b1;
         `CMD_ADDR: wr_hit = 1'b1;
         `IOBASE_ADDR: wr_hit = 1'b1;
         `IOLIMIT_ADDR: wr_hit = 1'b1;
         `STAT_ADDR: wr_hit = 1'b1;
         `MASK_ADDR: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end
      else
      begin
         if (awready_q && AWVALID_IN)
         begin
            awaddr_q <= AWADDR_IN;
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
         end
         else if (!aw_have_q)
            awready_q <= 1'b1;
         if (wready_q && WVALID_IN)
         begin
            wdata_q <= WDATA_IN;
            wstrb_q <= WSTRB_IN;
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
         end
         else if (!w_have_q)
            wready_q <= 1'b1;
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid_q && BREADY_IN)
            bvalid_q <= 1'b0;
      end
   end

   // Registers hold their reset values until software writes them.
   always @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         ctrl_q <= `CTRL_RESET;
         cmd_q <= `CMD_RESET;
         io_base_q <= `WIN_RESET;
         io_limit_q <= `WIN_RESET;
         mask_q <= `MASK_RESET;
      end
      else if (wr_go)
      begin
         case (awaddr_q)
            `CTRL_ADDR:
               ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q, `CTRL_WMASK);
            `CMD_ADDR:
               cmd_q <= merge(cmd_q, wdata_q, wstrb_q, `CMD_WMASK);
            `IOBASE_ADDR:
               io_base_q <= merge(io_base_q, wdata_q, wstrb_q, `WIN_WMASK);
            `IOLIMIT_ADDR:
               io_limit_q <= merge(io_limit_q, wdata_q, wstrb_q, `WIN_WMASK);
            `MASK_ADDR:
               if (wstrb_q[0])
                  mask_q <= wdata_q[`STAT_W-1:0];
            default:
               mask_q <= mask_q;
         endcase
      end
   end

   // Read channel; one read in flight, answered the cycle after acceptance.
   assign rd_go = arready_q && ARVALID_IN;
   assign stat_rd = rd_go && (ARADDR_IN == `STAT_ADDR);

   always @*
   begin
      rd_hit = 1'b1;
      case (ARADDR_IN)
         `CTRL_ADDR: rd_mux = ctrl_q;
         `CMD_ADDR: rd_mux = cmd_q;
         `IOBASE_ADDR: rd_mux = io_base_q;
         `IOLIMIT_ADDR: rd_mux = io_limit_q;
         `STAT_ADDR: rd_mux = {{(32-`STAT_W){1'b0}}, stat_q};
         `MASK_ADDR: rd_mux = {{(32-`STAT_W){1'b0}}, mask_q};
         default:
         begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `RESP_OKAY;
      end
      else if (rd_go)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && RREADY_IN)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
      else if (!rvalid_q)
         arready_q <= 1'b1;
   end

   // Error reporting toward both buses.
   // Address parity reaches the primary pin only with response on.
   assign addr_perr_report = S_ADDR_PERR_DET_IN && perr_resp && serr_en;
   // Secondary error forwarding needs both enables.
   assign sec_serr_report = !S_SERR_N_IN && serr_fwd && serr_en;

   always @*
   begin
      stat_set = {`STAT_W{1'b0}};
      stat_set[`ST_DATA_PERR] = S_DATA_PERR_DET_IN;
      stat_set[`ST_ADDR_PERR] = S_ADDR_PERR_DET_IN;
      stat_set[`ST_SEC_SERR] = !S_SERR_N_IN;
      stat_set[`ST_PRI_SERR] = addr_perr_report || sec_serr_report;
      // Reported flag only with response on, as bus master.
      stat_set[`ST_PERR_RPT] = S_DATA_PERR_DET_IN && perr_resp &&
                               S_BRIDGE_MASTER_IN;
   end

   sticky_flags #(
      .W(`STAT_W)
   ) u_status (
      .clk_in(CLK_IN),
      .resetn_in(RESETN_IN),
      .set_in(stat_set),
      .clear_in(stat_rd),
      .flags_q(stat_q)
   );

   always @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         s_perr_q <= 1'b0;
         s_perr_n_q <= 1'b1;
         p_serr_q <= 1'b0;
         p_serr_n_q <= 1'b1;
         irq_q <= 1'b0;
      end
      else
      begin
         // Parity pin driven only with response on.
         s_perr_q <= S_DATA_PERR_DET_IN && perr_resp;
         s_perr_n_q <= !(S_DATA_PERR_DET_IN && perr_resp);
         p_serr_q <= addr_perr_report || sec_serr_report;
         p_serr_n_q <= !(addr_perr_report || sec_serr_report);
         irq_q <= |(stat_q & mask_q);
      end
   end

   // Address decode on both buses.
   legacy_addr_match u_pri_match (
      .addr_in(P_REQ_ADDR_IN),
      .io_base_in(io_base_q),
      .io_limit_in(io_limit_q),
      .in_window_out(p_in_win),
      .low64k_alias_out(p_alias),
      .vga_io_out(p_vga_io),
      .vga_mem_out(p_vga_mem)
   );

   legacy_addr_match u_sec_match (
      .addr_in(S_REQ_ADDR_IN),
      .io_base_in(io_base_q),
      .io_limit_in(io_limit_q),
      .in_window_out(s_in_win),
      .low64k_alias_out(s_alias),
      .vga_io_out(s_vga_io),
      .vga_mem_out(s_vga_mem)
   );

   // VGA forwarding needs both space enables.
   assign vga_ok = vga_mode && io_en && mem_en;
   // Window claim with alias holes removed.
   assign p_io_hit = io_en && p_in_win && !(alias_mode && p_alias);
   // Upstream I/O: outside window or aliased, never VGA I/O while VGA mode is on.
   assign s_io_hit = (!s_in_win || (alias_mode && s_alias)) &&
                     !(vga_mode && s_vga_io);

   always @(posedge CLK_IN)
   begin
      if (!RESETN_IN)
      begin
         p_claim_q <= 1'b0;
         s_claim_q <= 1'b0;
      end
      else
      begin
         // VGA ranges claimed regardless of window and alias mode, only with VGA mode and both space enables on.
         if (P_REQ_IS_IO_IN)
            p_claim_q <= P_REQ_VALID_IN && (p_io_hit || (vga_ok && p_vga_io));
         else
            p_claim_q <= P_REQ_VALID_IN && vga_ok && p_vga_mem;
         // Secondary memory in the VGA range is never claimed here.
         s_claim_q <= S_REQ_VALID_IN && S_REQ_IS_IO_IN && s_io_hit &&
                      !(vga_mode && s_vga_mem);
      end
   end

   assign AWREADY_OUT = awready_q;
   assign WREADY_OUT = wready_q;
   assign BVALID_OUT = bvalid_q;
   assign BRESP_OUT = bresp_q;
   assign ARREADY_OUT = arready_q;
   assign RVALID_OUT = rvalid_q;
   assign RDATA_OUT = rdata_q;
   assign RRESP_OUT = rresp_q;
   assign S_PERR_N_OUT = s_perr_n_q;
   assign S_PERR_OE_OUT = s_perr_q;
   assign P_SERR_N_OUT = p_serr_n_q;
   assign P_SERR_OE_OUT = p_serr_q;
   assign P_CLAIM_OUT = p_claim_q;
   assign S_CLAIM_OUT = s_claim_q;
   assign IRQ_OUT = irq_q;
endmodule // legacy_decode_ctrl

// file: hw/sticky_flags.v
// Sticky event flags, cleared as a whole by a read strobe.
// A set arriving with the clear survives it.
module sticky_flags #(
   parameter W = 5
) (
   input wire clk_in,
   input wire resetn_in,
   input wire [W-1:0] set_in,
   input wire clear_in,
   output reg [W-1:0] flags_q
);
   always @(posedge clk_in)
   begin
      if (!resetn_in)
         flags_q <= {W{1'b0}};
      else if (clear_in)
         flags_q <= set_in;
      else
         flags_q <= flags_q | set_in;
   end
endmodule // sticky_flags

// file: inc/legacy_decode_defs.vh
// Register map, field positions and reset values of the legacy decode block.
// Assumes an AXI4-Lite slave with 32-bit data and 12-bit byte addresses.
`ifndef LEGACY_DECODE_DEFS_VH
`define LEGACY_DECODE_DEFS_VH

// Control register index; its byte address is four times the index.
`define CTRL_IDX 12'h03e
`define CTRL_ADDR 12'h0f8
`define CMD_ADDR 12'h000
`define IOBASE_ADDR 12'h004
`define IOLIMIT_ADDR 12'h008
`define STAT_ADDR 12'h00c
`define MASK_ADDR 12'h010

// Control register fields.
`define CTRL_PERR_RESP 16
`define CTRL_SERR_FWD 17
`define CTRL_ALIAS 18
`define CTRL_VGA 19
`define CTRL_WMASK 32'h000f0000
`define CTRL_RESET 32'h00000000

// Command register fields.
`define CMD_IO_EN 0
`define CMD_MEM_EN 1
`define CMD_SERR_EN 8
`define CMD_WMASK 32'h00000103
`define CMD_RESET 32'h00000000

// Window registers keep address bits 31:12.
`define WIN_WMASK 32'hfffff000
`define WIN_RESET 32'h00000000

// Status and mask bits.
`define STAT_W 5
`define ST_DATA_PERR 0
`define ST_ADDR_PERR 1
`define ST_SEC_SERR 2
`define ST_PRI_SERR 3
`define ST_PERR_RPT 4
`define MASK_RESET 5'h00

// Legacy ranges.
`define VGA_MEM_LO 32'h000a0000
`define VGA_MEM_HI 32'h000bffff
`define VGA_IO_LO1 10'h3b0
`define VGA_IO_HI1 10'h3bb
`define VGA_IO_LO2 10'h3c0
`define VGA_IO_HI2 10'h3df

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: verification/legacy_decode_monitor.sv
// Checker for the legacy decode block, bound to its top ports.
// Assumes the error inputs are one-cycle strobes synchronous to CLK_IN.
module legacy_decode_monitor (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic S_DATA_PERR_DET_IN,
   input wire logic S_ADDR_PERR_DET_IN,
   input wire logic S_SERR_N_IN,
   input wire logic S_PERR_N_OUT,
   input wire logic S_PERR_OE_OUT,
   input wire logic P_SERR_N_OUT,
   input wire logic P_SERR_OE_OUT,
   input wire logic P_REQ_VALID_IN,
   input wire logic P_REQ_IS_IO_IN,
   input wire logic [31:0] P_REQ_ADDR_IN,
   input wire logic P_CLAIM_OUT,
   input wire logic S_REQ_VALID_IN,
   input wire logic S_REQ_IS_IO_IN,
   input wire logic S_CLAIM_OUT,
   input wire logic BVALID_OUT,
   input wire logic BREADY_IN,
   input wire logic RVALID_OUT,
   input wire logic RREADY_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   property p_perr_cause;
      S_PERR_OE_OUT |-> $past(S_DATA_PERR_DET_IN);
   endproperty
   property p_perr_pin;
      S_PERR_N_OUT != S_PERR_OE_OUT;
   endproperty
   property p_serr_cause;
      P_SERR_OE_OUT |-> $past(S_ADDR_PERR_DET_IN || !S_SERR_N_IN);
   endproperty
   property p_serr_pin;
      P_SERR_N_OUT != P_SERR_OE_OUT;
   endproperty
   property p_pclaim;
      P_CLAIM_OUT |-> $past(P_REQ_VALID_IN);
   endproperty
   property p_pmem;
      P_REQ_VALID_IN && !P_REQ_IS_IO_IN && (P_REQ_ADDR_IN < 32'h000a0000
         || P_REQ_ADDR_IN > 32'h000bffff) |=> !P_CLAIM_OUT;
   endproperty
   property p_sclaim;
      S_CLAIM_OUT |-> $past(S_REQ_VALID_IN && S_REQ_IS_IO_IN);
   endproperty
   property p_bhold;
      BVALID_OUT && !BREADY_IN |=> BVALID_OUT;
   endproperty
   property p_rhold;
      RVALID_OUT && !RREADY_IN |=> RVALID_OUT;
   endproperty
   a_perr_cause: assert property (p_perr_cause)
      else $error("parity pin without detection");
   a_perr_pin: assert property (p_perr_pin)
      else $error("parity pin level and enable disagree");
   a_serr_cause: assert property (p_serr_cause)
      else $error("system error pin without cause");
   a_serr_pin: assert property (p_serr_pin)
      else $error("system error level and enable disagree");
   a_pclaim: assert property (p_pclaim)
      else $error("primary claim without request");
   a_pmem: assert property (p_pmem)
      else $error("memory claim outside legacy range");
   a_sclaim: assert property (p_sclaim)
      else $error("secondary claim without I/O request");
   a_bhold: assert property (p_bhold)
      else $error("write response dropped early");
   a_rhold: assert property (p_rhold)
      else $error("read response dropped early");
   c_perr: cover property (S_PERR_OE_OUT);
   c_serr: cover property (P_SERR_OE_OUT);
   c_claim: cover property (P_CLAIM_OUT ##2 S_CLAIM_OUT);
endmodule // legacy_decode_monitor

bind legacy_decode_ctrl legacy_decode_monitor u_monitor (.*);

// file: verification/sec_bus_agent.sv
// Model of the secondary bus agents: raises one error event per request.
// Assumes requests from the bench are at least one clock apart.
module sec_bus_agent (
   input wire logic clk_in,
   input wire logic go_in,
   input wire logic [1:0] kind_in,
   output logic data_perr_out,
   output logic master_out,
   output logic addr_perr_out,
   output logic serr_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {data_perr_out, master_out, addr_perr_out, serr_n_out} = 4'h1;
   // Kind 0 data error as master, 1 as target, 2 address, 3 system.
   always @(posedge clk_in)
   begin
      data_perr_out <= go_in && !kind_in[1];
      master_out <= go_in && kind_in == 2'd0;
      addr_perr_out <= go_in && kind_in == 2'd2;
      serr_n_out <= !(go_in && kind_in == 2'd3);
   end
endmodule // sec_bus_agent

// file: verification/testbench.sv
// Self-checking bench of the legacy decode block.
// Assumes the register map of legacy_decode_defs.vh.
`include "legacy_decode_defs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, go = 0;
   logic [1:0] kind = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, p_a = 0, s_a = 0, rd_q;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic p_v = 0, p_io = 0, s_v = 0, s_io = 0;
   logic [1:0] resp_q;
   wire dperr, mst, aperr, serr_n, awready, wready, bvalid, arready, rvalid;
   wire s_perr_n, s_perr_oe, p_serr_n, p_serr_oe, p_claim, s_claim, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int miscompares = 0, checks_done = 0, cycles = 0;
   sec_bus_agent u_agent (.clk_in(clk), .go_in(go), .kind_in(kind),
      .data_perr_out(dperr), .master_out(mst), .addr_perr_out(aperr),
      .serr_n_out(serr_n));
   legacy_decode_ctrl DUT (.CLK_IN(clk), .RESETN_IN(rst_n),
      .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
      .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid),
      .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
      .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
      .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
      .RVALID_OUT(rvalid), .RREADY_IN(rready), .S_DATA_PERR_DET_IN(dperr),
      .S_BRIDGE_MASTER_IN(mst), .S_ADDR_PERR_DET_IN(aperr),
      .S_SERR_N_IN(serr_n), .S_PERR_N_OUT(s_perr_n),
      .S_PERR_OE_OUT(s_perr_oe), .P_SERR_N_OUT(p_serr_n),
      .P_SERR_OE_OUT(p_serr_oe), .P_REQ_VALID_IN(p_v),
      .P_REQ_IS_IO_IN(p_io), .P_REQ_ADDR_IN(p_a), .P_CLAIM_OUT(p_claim),
      .S_REQ_VALID_IN(s_v), .S_REQ_IS_IO_IN(s_io), .S_REQ_ADDR_IN(s_a),
      .S_CLAIM_OUT(s_claim), .IRQ_OUT(irq));
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         test_done();
      end
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      int n;
      bit ad, wd;
      n = 0;
      ad = 0;
      wd = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ad && wd) && n < 50)
      begin
         @(posedge clk);
         n++;
         ad = ad || awready;
         wd = wd || wready;
         awvalid <= !ad;
         wvalid <= !wd;
      end
      do @(posedge clk); while (!bvalid && ++n < 50);
      resp_q = bresp;
      bready <= 0;
      if (n >= 50) miscompares++;
   endtask
   task automatic rd(logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge clk); while (!arready && ++n < 50);
      arvalid <= 0;
      do @(posedge clk); while (!rvalid && ++n < 50);
      rd_q = rdata;
      resp_q = rresp;
      rready <= 0;
      if (n >= 50) miscompares++;
   endtask
   task automatic fire(logic [1:0] k);
      @(posedge clk);
      go <= 1;
      kind <= k;
      @(posedge clk);
      go <= 0;
      @(posedge clk);
      #1;
   endtask
   task automatic req(bit s, bit io, logic [31:0] a, bit exp);
      @(posedge clk);
      p_v <= !s;
      s_v <= s;
      p_io <= io;
      s_io <= io;
      p_a <= a;
      s_a <= a;
      @(posedge clk);
      p_v <= 0;
      s_v <= 0;
      #1;
      check("claim", 32'(s ? s_claim : p_claim), 32'(exp));
   endtask
   task automatic t_regs();
      rd(`CTRL_ADDR);
      check("ctrl reset", rd_q, 32'h00000000);
      wr(`CTRL_ADDR, 32'hffffffff);
      check("ctrl wr resp", 32'(resp_q), 32'h0);
      wr(12'h100, 32'hffffffff);
      check("unmapped wr resp", 32'(resp_q), 32'h2);
      rd(`CTRL_ADDR);
      check("ctrl bits", rd_q, 32'h000f0000);
      rd(12'h100);
      check("unmapped read", {rd_q[29:0], resp_q}, 32'h00000002);
   endtask
   task automatic t_parity();
      wr(`CMD_ADDR, 32'h00000103);
      wr(`MASK_ADDR, 32'h0000001f);
      for (int i = 0; i < 3; i++)
      begin
         wr(`CTRL_ADDR, 32'(i > 0) << 16);
         rd(`STAT_ADDR);
         fire(2'(i == 2));
         check("perr oe", 32'(s_perr_oe), 32'(i > 0));
         check("perr n", 32'(s_perr_n), 32'(i == 0));
         @(posedge clk);
         #1;
         check("irq set", 32'(irq), 32'h1);
         rd(`STAT_ADDR);
         check("status", rd_q, i == 1 ? 32'h11 : 32'h01);
         repeat (2) @(posedge clk);
         #1;
         check("irq clear", 32'(irq), 32'h0);
      end
      wr(`MASK_ADDR, 32'h00000000);
      fire(2'd0);
      @(posedge clk);
      #1;
      check("irq masked", 32'(irq), 32'h0);
   endtask
   task automatic t_serr();
      rd(`STAT_ADDR);
      for (int i = 0; i < 8; i++)
      begin
         wr(`CMD_ADDR, i < 4 ? 32'h00000103 : 32'h00000003);
         wr(`CTRL_ADDR, 32'(i % 4) << 16);
         fire(2'd2);
         check("addr serr", 32'(p_serr_oe), 32'(i == 1 || i == 3));
         check("addr serr n", 32'(p_serr_n), 32'(!(i == 1 || i == 3)));
         fire(2'd3);
         check("fwd serr", 32'(p_serr_oe), 32'(i == 2 || i == 3));
      end
      rd(`STAT_ADDR);
      check("serr status", rd_q, 32'h0000000e);
   endtask
   task automatic t_decode();
      wr(`CMD_ADDR, 32'h00000103);
      wr(`IOBASE_ADDR, 32'h00001000);
      wr(`IOLIMIT_ADDR, 32'h00001000);
      wr(`CTRL_ADDR, 32'h00000000);
      req(0, 1, 32'h00001100, 1);
      req(0, 1, 32'h00002000, 0);
      req(0, 1, 32'h000003b0, 0);
      req(0, 0, 32'h000a0000, 0);
      wr(`CTRL_ADDR, 32'h00040000);
      req(0, 1, 32'h00001100, 0);
      req(0, 1, 32'h00001010, 1);
      req(1, 1, 32'h00001100, 1);
      req(1, 1, 32'h00001010, 0);
      wr(`CTRL_ADDR, 32'h00080000);
      req(0, 0, 32'h000bffff, 1);
      req(0, 0, 32'h000c0000, 0);
      req(0, 1, 32'h000003bb, 1);
      req(0, 1, 32'h000003bc, 0);
      req(0, 1, 32'h000003df, 1);
      req(0, 1, 32'h00007fc0, 1);
      req(0, 1, 32'h000103c0, 0);
      req(1, 1, 32'h000003b0, 0);
      req(1, 0, 32'h000a0000, 0);
      wr(`CMD_ADDR, 32'h00000102);
      req(0, 0, 32'h000a0000, 0);
   endtask
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      t_regs();
      t_parity();
      t_serr();
      t_decode();
      test_done();
   end
endmodule // testbench
